// File: core/nvm_access_defs.vh
`ifndef NVM_ACCESS_DEFS_VH
`define NVM_ACCESS_DEFS_VH

// i/o register indices
`define IO_STORAGE_0 6'h0a
`define IO_STORAGE_1 6'h0b
`define IO_STORAGE_2 6'h0c
`define IO_CONTROL 6'h1c
`define IO_DATA 6'h1d
`define IO_ADDR_LOW 6'h1e
`define IO_ADDR_HIGH 6'h1f

// address space layout
`define DATA_SPACE_OFFSET 8'h20
`define IO_SPACE_END 8'h40
`define DATA_SPACE_END 8'h60
`define BIT_ACCESS_END 6'h20

// control register fields
`define CTRL_READ_STROBE 0
`define CTRL_PROGRAM_ENABLE 1
`define CTRL_MASTER_ENABLE 2
`define CTRL_READY_IRQ_EN 3
`define CTRL_MODE_LOW 4
`define CTRL_MODE_HIGH 5

// mode field encodings
`define MODE_ATOMIC 2'b00
`define MODE_ERASE 2'b01
`define MODE_WRITE 2'b10
`define MODE_RESERVED 2'b11

// reset values
`define STORAGE_RESET 8'h00
`define DATA_RESET 8'h00
`define MODE_RESET 2'b00
`define ADDR_POWERUP 9'h000
`define ERASED_BYTE 8'hff

// timing
`define MASTER_WINDOW_CYCLES 3'd4
`define PROGRAM_STALL_CYCLES 3'd2
`define READ_STALL_CYCLES 3'd4
`define CLK_MHZ 20'd100
`define ATOMIC_TIME_US 20'd3400
`define SPLIT_TIME_US 20'd1800
`define ATOMIC_CYCLES (`ATOMIC_TIME_US * `CLK_MHZ)
`define SPLIT_CYCLES (`SPLIT_TIME_US * `CLK_MHZ)

// array geometry
`define ARRAY_DEPTH 512
`define ARRAY_ADDR_W 9
`define TIMER_W 20

`endif

// File: core/nvm_program_timer.v
`timescale 1ns/1ns
`include "nvm_access_defs.vh"

module nvm_program_timer #(
	parameter [`TIMER_W-1:0] ATOMIC_CYCLES = `ATOMIC_CYCLES,
	parameter [`TIMER_W-1:0] SPLIT_CYCLES = `SPLIT_CYCLES
) (
	input wire core_clk_i,
	input wire por_i,
	input wire start_i,
	input wire [1:0] mode_i,
	output reg done_o,
	output wire running_o
);
	reg [`TIMER_W-1:0] count;
	reg running;

	assign running_o = running;

	// only power-on stops it: a system reset must let the operation finish
	always @(posedge core_clk_i) begin
		if (por_i) begin
			count <= {`TIMER_W{1'b0}};
			running <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !running) begin
				running <= 1'b1;
				if (mode_i == `MODE_ATOMIC)
					count <= ATOMIC_CYCLES - 1'b1; // RQ4
				else
					count <= SPLIT_CYCLES - 1'b1; // RQ4
			end else if (running) begin
				if (count == {`TIMER_W{1'b0}}) begin
					running <= 1'b0;
					done_o <= 1'b1; // RQ7
				end else begin
					count <= count - 1'b1;
				end
			end
		end
	end
endmodule

// File: core/nvm_byte_array.v
`timescale 1ns/1ns
`include "nvm_access_defs.vh"

module nvm_byte_array (
	input wire core_clk_i,
	input wire commit_i,
	input wire [1:0] mode_i,
	input wire [`ARRAY_ADDR_W-1:0] prog_addr_i,
	input wire [7:0] prog_data_i,
	input wire [`ARRAY_ADDR_W-1:0] read_addr_i,
	output wire [7:0] read_data_o
);
	// contents are nonvolatile, so no reset
	reg [7:0] mem [0:`ARRAY_DEPTH-1];

	assign read_data_o = mem[read_addr_i];

	always @(posedge core_clk_i) begin
		if (commit_i) begin
			case (mode_i)
				`MODE_ATOMIC: mem[prog_addr_i] <= prog_data_i;
				`MODE_ERASE: mem[prog_addr_i] <= `ERASED_BYTE;
				// write only clears bits; unerased bytes end up as an and
				`MODE_WRITE: mem[prog_addr_i] <= mem[prog_addr_i] & prog_data_i;
				default: mem[prog_addr_i] <= mem[prog_addr_i]; // RQ25
			endcase
		end
	end
endmodule

// File: core/eeprom_access_controller.v
// Operation
// RQ1 - master program enable self-clears four cycles after software sets it
// RQ2 - program starts only when enable follows master enable within four cycles
// RQ3 - program enable without master enable does nothing to the array
// RQ4 - mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms
// RQ5 - mode bits ignore writes while program enable is set
// RQ6 - reset returns mode to 00 unless programming is in progress
// RQ7 - program enable stays set for the whole operation, then hardware clears it
// RQ8 - setting program enable stalls the cpu for two cycles
// RQ9 - read strobe loads the addressed byte into the data register at once
// RQ10 - a read strobe stalls the cpu for four cycles
// RQ11 - while programming, read strobes and address writes are rejected
// RQ12 - software polls program enable low before issuing a read strobe
// RQ13 - ready interrupt held while enabled, globally enabled and not programming
// RQ14 - data register supplies write data and receives read data
// RQ15 - nine-bit address split over low byte and high byte bit zero
// RQ16 - address powers up undefined; software writes it before access
// RQ17 - a reset during programming does not abort the operation
// RQ18 - control bits 7:6 and address high bits 7:1 read as zero
// RQ19 - three general storage registers, read-write, reset to zero
// RQ20 - registers below 0x20 allow single-bit set and clear of one bit only
// RQ21 - every i/o register also sits in data space at address plus 0x20
// RQ22 - software writes reserved bits as zero and never reserved addresses
// RQ23 - programming time is measured on the calibrated block clock
// RQ24 - software erases before a write-only operation
// RQ25 - trigger in reserved mode 11 leaves array alone, enable clears at once
// RQ26 - a new trigger is accepted only once the previous operation is done
`timescale 1ns/1ns
`include "nvm_access_defs.vh"

module eeprom_access_controller #(
	parameter [`TIMER_W-1:0] ATOMIC_CYCLES = `ATOMIC_CYCLES,
	parameter [`TIMER_W-1:0] SPLIT_CYCLES = `SPLIT_CYCLES
) (
	input wire core_clk_i,
	input wire srst_i,
	input wire por_i,
	input wire io_space_i,
	input wire [7:0] io_addr_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_wdata_i,
	input wire bit_op_i,
	input wire bit_val_i,
	input wire [2:0] bit_sel_i,
	input wire global_int_enable_i,
	output reg [7:0] io_rdata_o,
	output wire cpu_stall_o,
	output wire ready_irq_o
);
	// returns {hit, index}; data space is the i/o map shifted up
	function [6:0] io_decode;
		input space;
		input [7:0] addr;
		reg [7:0] shifted;
		begin
			shifted = addr - `DATA_SPACE_OFFSET;
			if (!space)
				io_decode = {(addr < `IO_SPACE_END), addr[5:0]};
			else if (addr >= `DATA_SPACE_OFFSET && addr < `DATA_SPACE_END)
				io_decode = {1'b1, shifted[5:0]}; // RQ21
			else
				io_decode = 7'h00;
		end
	endfunction

	function [7:0] merge;
		input [7:0] old;
		input [7:0] val;
		input [7:0] mask;
		begin
			merge = (old & ~mask) | (val & mask);
		end
	endfunction

	// one-hot program sequence: idle, timer start, timed run
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_START = 3'b010;
	localparam [2:0] ST_RUN = 3'b100;

	reg [7:0] storage_0;
	reg [7:0] storage_1;
	reg [7:0] storage_2;
	reg [7:0] nvm_data;
	reg [`ARRAY_ADDR_W-1:0] nvm_address;
	reg [1:0] nvm_mode_field;
	reg ready_interrupt_enable;
	reg master_program_enable;
	reg [2:0] master_count;
	reg program_enable;
	reg [2:0] stall_count;
	reg [1:0] op_mode;
	reg [`ARRAY_ADDR_W-1:0] op_addr;
	reg [7:0] op_data;
	reg start_pulse;
	reg [7:0] read_mux;
	reg [2:0] prog_state;
	reg [2:0] next_prog_state;

	wire [6:0] decoded = io_decode(io_space_i, io_addr_i);
	wire hit = decoded[6];
	wire [5:0] index = decoded[5:0];
	wire bit_ok = bit_op_i && !io_wr_i && (index < `BIT_ACCESS_END); // RQ20
	wire wr_any = hit && (io_wr_i || bit_ok);
	wire [7:0] wr_mask = io_wr_i ? 8'hff : (8'h01 << bit_sel_i); // RQ20
	wire [7:0] wr_val = io_wr_i ? io_wdata_i : {8{bit_val_i}};
	wire ctrl_wr = wr_any && index == `IO_CONTROL;
	wire [7:0] ctrl_bits = wr_val & wr_mask;
	wire [7:0] ctrl_now = {2'b00, nvm_mode_field, ready_interrupt_enable,
		master_program_enable, program_enable, 1'b0}; // RQ18
	wire [7:0] addr_low_now = nvm_address[7:0];
	wire [7:0] addr_high_now = {7'h00, nvm_address[8]}; // RQ18
	wire [7:0] addr_low_next = merge(addr_low_now, wr_val, wr_mask);
	wire [7:0] addr_high_next = merge(addr_high_now, wr_val, wr_mask);
	wire want_program = ctrl_wr && ctrl_bits[`CTRL_PROGRAM_ENABLE];
	wire want_read = ctrl_wr && ctrl_bits[`CTRL_READ_STROBE];
	wire timer_done;
	wire timer_running;
	wire [7:0] array_rdata;
	// busy covers the cycle between trigger and timer start too
	wire busy = program_enable || timer_running || start_pulse;
	wire trigger = want_program && master_program_enable && !busy; // RQ2 RQ3 RQ26
	// reserved mode is refused here, so enable never rises for it
	wire launch = trigger && nvm_mode_field != `MODE_RESERVED; // RQ25
	wire read_ok = want_read && !busy; // RQ11

	assign cpu_stall_o = stall_count != 3'd0;
	assign ready_irq_o = ready_interrupt_enable && global_int_enable_i && !busy; // RQ13

	always @* begin
		case (index)
			`IO_STORAGE_0: read_mux = storage_0;
			`IO_STORAGE_1: read_mux = storage_1;
			`IO_STORAGE_2: read_mux = storage_2;
			`IO_CONTROL: read_mux = ctrl_now;
			`IO_DATA: read_mux = nvm_data;
			`IO_ADDR_LOW: read_mux = addr_low_now;
			`IO_ADDR_HIGH: read_mux = addr_high_now;
			default: read_mux = 8'h00;
		endcase
	end

	always @* begin
		case (prog_state)
			ST_IDLE: begin
				if (launch)
					next_prog_state = ST_START;
				else
					next_prog_state = ST_IDLE;
			end
			ST_START: begin
				next_prog_state = ST_RUN;
			end
			ST_RUN: begin
				if (timer_done)
					next_prog_state = ST_IDLE;
				else
					next_prog_state = ST_RUN;
			end
			default: begin
				next_prog_state = ST_IDLE;
			end
		endcase
	end

	// general storage and read port follow the system reset
	always @(posedge core_clk_i) begin
		if (srst_i || por_i) begin
			storage_0 <= `STORAGE_RESET; // RQ19
			storage_1 <= `STORAGE_RESET; // RQ19
			storage_2 <= `STORAGE_RESET; // RQ19
			io_rdata_o <= 8'h00;
		end else begin
			if (wr_any && index == `IO_STORAGE_0)
				storage_0 <= merge(storage_0, wr_val, wr_mask); // RQ19
			if (wr_any && index == `IO_STORAGE_1)
				storage_1 <= merge(storage_1, wr_val, wr_mask); // RQ19
			if (wr_any && index == `IO_STORAGE_2)
				storage_2 <= merge(storage_2, wr_val, wr_mask); // RQ19
			if (io_rd_i)
				io_rdata_o <= hit ? read_mux : 8'h00;
		end
	end

	// data register: software writes, read strobe overrides in the same cycle
	always @(posedge core_clk_i) begin
		if (srst_i || por_i) begin
			nvm_data <= `DATA_RESET;
		end else if (read_ok) begin
			nvm_data <= array_rdata; // RQ9 RQ14
		end else if (wr_any && index == `IO_DATA) begin
			nvm_data <= merge(nvm_data, wr_val, wr_mask); // RQ14
		end
	end

	// address keeps its value over system reset; only power-on defines it
	always @(posedge core_clk_i) begin
		if (por_i) begin
			nvm_address <= `ADDR_POWERUP; // RQ16
		end else if (wr_any && !busy) begin
			if (index == `IO_ADDR_LOW)
				nvm_address[7:0] <= addr_low_next; // RQ15 RQ11
			if (index == `IO_ADDR_HIGH)
				nvm_address[8] <= addr_high_next[0]; // RQ15 RQ18
		end
	end

	// mode bits survive a system reset taken mid-operation
	always @(posedge core_clk_i) begin
		if (por_i) begin
			nvm_mode_field <= `MODE_RESET;
		end else if (srst_i) begin
			if (!busy)
				nvm_mode_field <= `MODE_RESET; // RQ6
		end else if (ctrl_wr && !program_enable) begin
			if (wr_mask[`CTRL_MODE_LOW])
				nvm_mode_field[0] <= wr_val[`CTRL_MODE_LOW]; // RQ5
			if (wr_mask[`CTRL_MODE_HIGH])
				nvm_mode_field[1] <= wr_val[`CTRL_MODE_HIGH]; // RQ5
		end
	end

	always @(posedge core_clk_i) begin
		if (srst_i || por_i) begin
			ready_interrupt_enable <= 1'b0;
		end else if (ctrl_wr && wr_mask[`CTRL_READY_IRQ_EN]) begin
			ready_interrupt_enable <= wr_val[`CTRL_READY_IRQ_EN];
		end
	end

	// master enable opens a window of four cycles
	always @(posedge core_clk_i) begin
		if (srst_i || por_i) begin
			master_program_enable <= 1'b0;
			master_count <= 3'd0;
		end else if (ctrl_wr && ctrl_bits[`CTRL_MASTER_ENABLE]) begin
			master_program_enable <= 1'b1;
			master_count <= `MASTER_WINDOW_CYCLES - 3'd1; // RQ1
		end else if (ctrl_wr && wr_mask[`CTRL_MASTER_ENABLE]) begin
			master_program_enable <= 1'b0;
			master_count <= 3'd0;
		end else if (master_program_enable) begin
			if (master_count == 3'd0)
				master_program_enable <= 1'b0; // RQ1
			else
				master_count <= master_count - 3'd1;
		end
	end

	// program enable: set by launch, cleared on completion, kept over srst
	always @(posedge core_clk_i) begin
		if (por_i) begin
			prog_state <= ST_IDLE;
			program_enable <= 1'b0;
			start_pulse <= 1'b0;
			op_mode <= `MODE_ATOMIC;
			op_addr <= `ADDR_POWERUP;
			op_data <= `DATA_RESET;
		end else begin
			prog_state <= next_prog_state;
			program_enable <= next_prog_state != ST_IDLE; // RQ2 RQ7 RQ17
			start_pulse <= next_prog_state == ST_START;
			if (launch) begin
				op_mode <= nvm_mode_field; // RQ4
				op_addr <= nvm_address;
				op_data <= nvm_data; // RQ14
			end
		end
	end

	// a reserved-mode trigger never raises enable, so it reads back clear at once
	always @(posedge core_clk_i) begin
		if (srst_i || por_i) begin
			stall_count <= 3'd0;
		end else if (read_ok) begin
			stall_count <= `READ_STALL_CYCLES; // RQ10
		end else if (launch) begin
			stall_count <= `PROGRAM_STALL_CYCLES; // RQ8
		end else if (stall_count != 3'd0) begin
			stall_count <= stall_count - 3'd1;
		end
	end

	// timing runs on the block clock, assumed to be the calibrated one
	nvm_program_timer #(
		.ATOMIC_CYCLES(ATOMIC_CYCLES),
		.SPLIT_CYCLES(SPLIT_CYCLES)
	) u_timer (
		.core_clk_i(core_clk_i),
		.por_i(por_i),
		.start_i(start_pulse),
		.mode_i(op_mode),
		.done_o(timer_done),
		.running_o(timer_running)
	); // RQ23

	nvm_byte_array u_array (
		.core_clk_i(core_clk_i),
		.commit_i(timer_done),
		.mode_i(op_mode),
		.prog_addr_i(op_addr),
		.prog_data_i(op_data),
		.read_addr_i(nvm_address),
		.read_data_o(array_rdata)
	); // RQ24
endmodule

// File: dv/eeprom_access_checker.sv
`timescale 1ns/1ns
module eeprom_access_checker (
	input wire core_clk_i,
	input wire srst_i,
	input wire por_i,
	input wire io_space_i,
	input wire [7:0] io_addr_i,
	input wire io_wr_i,
	input wire io_rd_i,
	input wire [7:0] io_wdata_i,
	input wire bit_op_i,
	input wire bit_val_i,
	input wire [2:0] bit_sel_i,
	input wire global_int_enable_i,
	input wire [7:0] io_rdata_o,
	input wire cpu_stall_o,
	input wire ready_irq_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (srst_i || por_i);
	wire [7:0] idx = io_space_i ? io_addr_i - 8'h20 : io_addr_i;
	wire bitw = bit_op_i && !io_wr_i && !io_space_i && bit_val_i && idx == 8'h1c;
	wire arm = (bitw && bit_sel_i == 3'd2) || (io_wr_i && idx == 8'h1c && io_wdata_i[2]);
	wire fire = bitw && bit_sel_i == 3'd1;
	wire strobe = bitw && bit_sel_i == 3'd0 && !cpu_stall_o;
	// saturates so a stale arm never looks fresh
	reg [2:0] since_arm;
	always @(posedge core_clk_i) begin
		if (srst_i || por_i)
			since_arm <= 3'd7;
		else if (arm)
			since_arm <= 3'd0;
		else if (since_arm != 3'd7)
			since_arm <= since_arm + 3'd1;
	end
	sequence s_arm_fire;
		arm ##1 fire;
	endsequence
	property p_prog_stall;
		s_arm_fire |=> cpu_stall_o [*2] ##1 !cpu_stall_o;
	endproperty
	a_prog_stall: assert property (p_prog_stall) else $error("program stall length wrong");
	property p_irq_busy;
		s_arm_fire |=> !ready_irq_o [*2];
	endproperty
	a_irq_busy: assert property (p_irq_busy) else $error("ready irq while busy");
	property p_read_stall;
		strobe |=> cpu_stall_o [*4] ##1 !cpu_stall_o;
	endproperty
	a_read_stall: assert property (p_read_stall) else $error("read stall length wrong");
	property p_late_fire;
		fire && since_arm >= 3'd4 |=> !cpu_stall_o;
	endproperty
	a_late_fire: assert property (p_late_fire) else $error("trigger without armed enable");
	property p_irq_gie;
		ready_irq_o |-> global_int_enable_i;
	endproperty
	a_irq_gie: assert property (p_irq_gie) else $error("irq without global enable");
	property p_rdata_hold;
		!io_rd_i && !srst_i && !por_i |=> $stable(io_rdata_o);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
	property p_ctrl_zero;
		io_rd_i && idx == 8'h1c |=> io_rdata_o[7:6] == 2'b00 && !io_rdata_o[0];
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero) else $error("control fixed bits set");
	property p_ahigh_zero;
		io_rd_i && idx == 8'h1f |=> io_rdata_o[7:1] == 7'h00;
	endproperty
	a_ahigh_zero: assert property (p_ahigh_zero) else $error("address high bits set");
endmodule

bind eeprom_access_controller eeprom_access_checker chk (.core_clk_i, .srst_i, .por_i,
	.io_space_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .bit_op_i, .bit_val_i,
	.bit_sel_i, .global_int_enable_i, .io_rdata_o, .cpu_stall_o, .ready_irq_o);

// File: dv/cpu_core_model.sv
`timescale 1ns/1ns
module cpu_core_model (
	input wire core_clk_i,
	input wire cpu_stall_i,
	input wire ready_irq_i,
	input wire gie_set_i,
	output logic gie_o,
	output int stall_cycles_o,
	output int irq_taken_o
);
	initial begin
		gie_o = 1'b0;
		stall_cycles_o = 0;
		irq_taken_o = 0;
	end
	// vectoring drops the enable, else a level request re-enters forever
	always @(posedge core_clk_i) begin
		if (cpu_stall_i)
			stall_cycles_o <= stall_cycles_o + 1;
		if (ready_irq_i && gie_o) begin
			gie_o <= 1'b0;
			irq_taken_o <= irq_taken_o + 1;
		end else if (gie_set_i)
			gie_o <= 1'b1;
	end
endmodule

// File: dv/eeprom_access_controller_tb.sv
`timescale 1ns/1ns
module eeprom_access_controller_tb;
	logic core_clk_i, srst_i, por_i, io_space_i, io_wr_i, io_rd_i, bit_op_i, bit_val_i, gie_set;
	logic [7:0] io_addr_i, io_wdata_i;
	logic [2:0] bit_sel_i;
	wire [7:0] io_rdata_o;
	wire cpu_stall_o, ready_irq_o, gie;
	int stalls, irqs, s0, n;
	int n_mismatch = 0;
	int checked = 0;
	eeprom_access_controller #(.ATOMIC_CYCLES(20'd40), .SPLIT_CYCLES(20'd20)) uut (.core_clk_i,
		.srst_i, .por_i, .io_space_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .bit_op_i,
		.bit_val_i, .bit_sel_i, .global_int_enable_i(gie), .io_rdata_o, .cpu_stall_o, .ready_irq_o);
	cpu_core_model cpu (.core_clk_i, .cpu_stall_i(cpu_stall_o), .ready_irq_i(ready_irq_o),
		.gie_set_i(gie_set), .gie_o(gie), .stall_cycles_o(stalls), .irq_taken_o(irqs));
	initial begin
		core_clk_i = 0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	task print_verdict;
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one bus cycle; every strobe is set once per edge
	task bus(input logic w, r, b, input logic [8:0] a, input logic [7:0] d, input logic [2:0] s);
		io_wr_i <= w;
		io_rd_i <= r;
		bit_op_i <= b;
		io_space_i <= a[8];
		io_addr_i <= a[7:0];
		io_wdata_i <= d;
		bit_val_i <= d[0];
		bit_sel_i <= s;
		@(posedge core_clk_i);
	endtask
	task idle(input int k);
		repeat (k) bus(0, 0, 0, 0, 0, 0);
	endtask
	task rd(input logic [8:0] a, input logic [7:0] exp);
		bus(0, 1, 0, a, 0, 0);
		idle(1);
		chk($sformatf("reg %h", a), exp, io_rdata_o);
	endtask
	task trig;
		bus(0, 0, 1, 9'h01c, 1, 2);
		bus(0, 0, 1, 9'h01c, 1, 1);
		idle(1);
	endtask
	task rst;
		srst_i <= 1;
		@(posedge core_clk_i);
		srst_i <= 0;
	endtask
	task wait_done(input int lo);
		n = 0;
		do begin
			bus(0, 1, 0, 9'h01c, 0, 0);
			idle(1);
			n += 2;
		end while (io_rdata_o[1] !== 1'b0 && n < 400);
		chk("busy cycles", 1, 8'(n >= lo - 6 && n <= lo + 6));
		if (n >= 400)
			print_verdict;
	endtask
	task rdback(input logic [7:0] exp);
		s0 = stalls;
		bus(0, 0, 1, 9'h01c, 1, 0);
		idle(5);
		chk("read stall", 4, 8'(stalls - s0));
		rd(9'h01d, exp);
	endtask
	initial begin
		{srst_i, por_i} = 2'b11;
		{io_space_i, io_wr_i, io_rd_i, bit_op_i, bit_val_i, gie_set} = 0;
		io_addr_i = 0;
		io_wdata_i = 0;
		bit_sel_i = 0;
		repeat (8) @(posedge core_clk_i);
		srst_i <= 0;
		por_i <= 0;
		for (int i = 10; i < 13; i++)
			rd(9'(i), 8'h00);
		rd(9'h01d, 8'h00);
		rd(9'h01c, 8'h00);
		bus(1, 0, 0, 9'h00b, 8'h3c, 0);
		bus(0, 0, 1, 9'h00b, 1, 7);
		bus(0, 0, 1, 9'h00b, 0, 2);
		rd(9'h12b, 8'hb8);
		bus(1, 0, 0, 9'h01f, 8'h01, 0);
		rd(9'h01f, 8'h01);
		$display("registers done");
		bus(1, 0, 0, 9'h01c, 8'h00, 0);
		bus(1, 0, 0, 9'h01e, 8'ha5, 0);
		bus(1, 0, 0, 9'h01d, 8'h5a, 0);
		s0 = stalls;
		trig;
		bus(1, 0, 0, 9'h01c, 8'h10, 0);
		bus(1, 0, 0, 9'h01e, 8'h00, 0);
		wait_done(40);
		chk("program stall", 2, 8'(stalls - s0));
		rd(9'h01c, 8'h00);
		rdback(8'h5a);
		$display("atomic done");
		bus(1, 0, 0, 9'h01c, 8'h10, 0);
		trig;
		rst;
		wait_done(20);
		rd(9'h01c, 8'h10);
		rdback(8'hff);
		rst;
		rd(9'h01c, 8'h00);
		bus(1, 0, 0, 9'h01c, 8'h20, 0);
		bus(1, 0, 0, 9'h01d, 8'h3c, 0);
		trig;
		wait_done(20);
		rdback(8'h3c);
		$display("split done");
		bus(0, 0, 1, 9'h01c, 1, 1);
		idle(1);
		rd(9'h01c, 8'h20);
		bus(0, 0, 1, 9'h01c, 1, 2);
		rd(9'h01c, 8'h24);
		idle(3);
		rd(9'h01c, 8'h20);
		bus(0, 0, 1, 9'h01c, 1, 1);
		idle(1);
		rd(9'h01c, 8'h20);
		bus(1, 0, 0, 9'h01c, 8'h30, 0);
		bus(0, 0, 1, 9'h01c, 1, 2);
		idle(1);
		bus(0, 0, 1, 9'h01c, 1, 1);
		idle(3);
		rd(9'h01c, 8'h30);
		rdback(8'h3c);
		$display("refusals done");
		bus(1, 0, 0, 9'h01c, 8'h08, 0);
		idle(3);
		chk("irq count", 0, 8'(irqs));
		gie_set <= 1;
		idle(1);
		gie_set <= 0;
		idle(2);
		chk("irq count", 1, 8'(irqs));
		trig;
		gie_set <= 1;
		idle(1);
		gie_set <= 0;
		idle(4);
		chk("irq while busy", 1, 8'(irqs));
		wait_done(40);
		chk("irq after ready", 2, 8'(irqs));
		$display("irq done");
		print_verdict;
	end
endmodule
